// ===== src/qpcs_pkg.sv
// Package: register map, field layout and carrier types of the quad config bank
package qpcs_pkg;
  localparam int QPCS_AW = 12;
  // Register indices; byte address is four times the index
  localparam logic [9:0] QPCS_IDX_SKIP_UP = 10'h013;
  localparam logic [9:0] QPCS_IDX_MASK_LO = 10'h014;
  localparam logic [9:0] QPCS_IDX_CHA_LO = 10'h015;
  localparam logic [9:0] QPCS_IDX_CHB_LO = 10'h016;
  localparam logic [9:0] QPCS_IDX_COMMA_UP = 10'h017;
  localparam logic [9:0] QPCS_IDX_MODE = 10'h018;
  localparam logic [9:0] QPCS_IDX_ALIGN = 10'h019;
  localparam logic [9:0] QPCS_IDX_RSVD_A = 10'h01a;
  localparam logic [9:0] QPCS_IDX_RSVD_B = 10'h01b;
  localparam logic [9:0] QPCS_IDX_IRQ_EN = 10'h01c;
  localparam logic [9:0] QPCS_IDX_IRQ_STAT = 10'h085;
  // Reset values
  localparam logic [7:0] QPCS_RST_SKIP_UP = 8'h05;
  localparam logic [7:0] QPCS_RST_MASK_LO = 8'h7f;
  localparam logic [7:0] QPCS_RST_CHA_LO = 8'h03;
  localparam logic [7:0] QPCS_RST_CHB_LO = 8'h7c;
  localparam logic [7:0] QPCS_RST_ZERO = 8'h00;
  // Writable bits; reserved bits read zero
  localparam logic [7:0] QPCS_WMASK_COMMA_UP = 8'hfc;
  localparam logic [7:0] QPCS_WMASK_MODE = 8'hfe;
  // Field positions
  localparam int QPCS_F_MASK_UP = 2;
  localparam int QPCS_F_CHA_UP = 4;
  localparam int QPCS_F_CHB_UP = 6;
  localparam int QPCS_F_QMODE = 1;
  localparam int QPCS_F_G8B10B = 3;
  localparam int QPCS_F_FC = 4;
  localparam int QPCS_F_PCIE = 5;
  localparam int QPCS_F_RIO = 6;
  localparam int QPCS_F_XAUI = 7;
  localparam int QPCS_F_NOLOCK = 0;
  localparam int QPCS_F_QUAD_AL = 1;
  localparam int QPCS_F_AL23 = 2;
  localparam int QPCS_F_AL01 = 3;
  localparam int QPCS_F_TXGEAR = 4;
  localparam int QPCS_F_RXGEAR = 5;
  localparam int QPCS_F_TPOLY = 6;
  localparam int QPCS_F_PPOLY = 7;
  localparam int QPCS_F_GAIN = 4;
  // Quad mode codes
  localparam logic [1:0] QPCS_QM_SONET = 2'h1;
  localparam logic [1:0] QPCS_QM_SER8 = 2'h3;
  // Tap masks: bit k-1 set for term x^k
  localparam logic [30:0] QPCS_TPOLY_SHORT = 31'h00000060;
  localparam logic [30:0] QPCS_TPOLY_LONG = 31'h48000000;
  localparam logic [15:0] QPCS_PPOLY_D10 = 16'hd008;
  localparam logic [15:0] QPCS_PPOLY_D10A = 16'h801c;
  localparam logic [1:0] QPCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] QPCS_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    sel_skip_up, sel_mask_lo, sel_cha_lo, sel_chb_lo, sel_comma_up,
    sel_mode, sel_align, sel_rsvd, sel_irq_en, sel_irq_stat, sel_none
  } qpcs_sel_type;

  typedef struct packed {
    logic [3:0] skip_disp_err;
    logic [3:0] skip_k_ctrl;
    logic [9:0] comma_mask;
    logic [9:0] comma_a;
    logic [9:0] comma_b;
    logic [1:0] quad_mode;
    logic sonet_mode;
    logic serdes8_mode;
    logic generic_8b10b;
    logic fibre_channel;
    logic pci_express;
    logic rapidio;
    logic xaui;
    logic aligner_lock_block;
    logic quad_align;
    logic align_ch23;
    logic align_ch01;
    logic tx_gear_2to1;
    logic rx_gear_2to1;
    logic test_poly_long;
    logic [30:0] test_poly_taps;
    logic pcie_poly_d10;
    logic [15:0] pcie_poly_taps;
  } qpcs_cfg_type;
endpackage

// ===== src/qpcs_config_regs.sv
// Quad coding-layer configuration bank behind an AXI4-Lite slave
// Contract
// - Skip pattern upper bits: even bit disparity error, odd bit K flag, four patterns.
// - Ten-bit comma mask from low register plus two shared upper bits.
// - Comma characters a and b: own low byte plus two shared upper bits.
// - Two-bit quad mode: other, SONET, reserved, eight-bit serializer only.
// - Single bits select 8b10b, Fibre Channel, PCI Express, RapidIO, XAUI.
// - Set bit blocks sync state machine from locking word aligner.
// - One bit picks four-channel alignment versus independent channels.
// - Two bits enable joint alignment of channels 2/3 and 0/1.
// - Bit enables 2:1 transmit gearing on all channels.
// - Bit enables 2:1 receive gearing on all channels.
// - Bit picks test polynomial x^7+x^6+1 or x^31+x^28+1.
// - Bit picks PCI Express scrambler polynomial of two drafts.
// - Per-channel enables for sync-loss events, status bits 0 to 3.
// - Per-channel enables for sync-gain events, status bits 4 to 7.
//
// The AXI4-Lite interface to the registers was left to the implementer.
module qpcs_config_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [qpcs_pkg::QPCS_AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [qpcs_pkg::QPCS_AW-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [3:0] link_sync,
  output qpcs_pkg::qpcs_cfg_type cfg,
  output logic irq
);
  import qpcs_pkg::*;

  typedef enum logic {wr_collect, wr_respond} qpcs_wr_type;

  typedef struct packed {
    qpcs_wr_type wr_state;
    logic aw_got;
    logic w_got;
    logic [QPCS_AW-1:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane;
    logic [1:0] b_resp;
    logic r_valid;
    logic [7:0] r_data;
    logic [1:0] r_resp;
    logic [7:0] skip_up;
    logic [7:0] mask_lo;
    logic [7:0] cha_lo;
    logic [7:0] chb_lo;
    logic [7:0] comma_up;
    logic [7:0] mode;
    logic [7:0] align;
    logic [7:0] irq_en;
    logic [7:0] irq_stat;
    logic [3:0] sync_meta;
    logic [3:0] sync_s;
    logic [3:0] sync_d;
  } qpcs_state_type;

  qpcs_state_type st;
  qpcs_state_type next_st;
  logic wr_fire;
  qpcs_sel_type wr_sel;
  logic [7:0] wr_data_eff;
  logic [7:0] sync_events;

  ////////////////////////////////////////////////////////////////////////
  // Address decode, shared by both channels
  function automatic qpcs_sel_type qpcs_decode(input logic [QPCS_AW-1:0] a);
    logic [9:0] idx;
    idx = a[QPCS_AW-1:2];
    case (idx)
      QPCS_IDX_SKIP_UP: qpcs_decode = sel_skip_up;
      QPCS_IDX_MASK_LO: qpcs_decode = sel_mask_lo;
      QPCS_IDX_CHA_LO: qpcs_decode = sel_cha_lo;
      QPCS_IDX_CHB_LO: qpcs_decode = sel_chb_lo;
      QPCS_IDX_COMMA_UP: qpcs_decode = sel_comma_up;
      QPCS_IDX_MODE: qpcs_decode = sel_mode;
      QPCS_IDX_ALIGN: qpcs_decode = sel_align;
      QPCS_IDX_RSVD_A, QPCS_IDX_RSVD_B: qpcs_decode = sel_rsvd;
      QPCS_IDX_IRQ_EN: qpcs_decode = sel_irq_en;
      QPCS_IDX_IRQ_STAT: qpcs_decode = sel_irq_stat;
      default: qpcs_decode = sel_none;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus handshakes
  assign awready = !st.aw_got && (st.wr_state == wr_collect);
  assign wready = !st.w_got && (st.wr_state == wr_collect);
  assign bvalid = (st.wr_state == wr_respond);
  assign bresp = st.b_resp;
  assign arready = !st.r_valid;
  assign rvalid = st.r_valid;
  assign rresp = st.r_resp;
  assign rdata = {24'h000000, st.r_data};

  // Write happens once both address and data are in, either order
  assign wr_fire = (st.aw_got || (awvalid && awready))
                && (st.w_got || (wvalid && wready));
  assign wr_sel = qpcs_decode(st.aw_got ? st.aw_addr : awaddr);
  assign wr_data_eff = st.w_got ? st.w_data : wdata[7:0];

  // Sync-loss in low nibble, sync-gain in high nibble
  assign sync_events = {st.sync_s & ~st.sync_d, ~st.sync_s & st.sync_d};

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic lane;
    lane = st.w_got ? st.w_lane : wstrb[0];
    next_st = st;
    // Link status is a pin level: two flops before the edge detector
    next_st.sync_meta = link_sync;
    next_st.sync_s = st.sync_meta;
    next_st.sync_d = st.sync_s;
    if (awvalid && awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_got = 1'b1;
      next_st.w_data = wdata[7:0];
      next_st.w_lane = wstrb[0];
    end
    // Set wins over a same-cycle write-one clear
    next_st.irq_stat = st.irq_stat | sync_events;
    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.wr_state = wr_respond;
      next_st.b_resp = (wr_sel == sel_none) ? QPCS_RESP_SLVERR : QPCS_RESP_OKAY;
      if (lane) begin
        case (wr_sel)
          sel_skip_up: next_st.skip_up = wr_data_eff;
          sel_mask_lo: next_st.mask_lo = wr_data_eff;
          sel_cha_lo: next_st.cha_lo = wr_data_eff;
          sel_chb_lo: next_st.chb_lo = wr_data_eff;
          sel_comma_up: next_st.comma_up = wr_data_eff & QPCS_WMASK_COMMA_UP;
          sel_mode: next_st.mode = wr_data_eff & QPCS_WMASK_MODE;
          sel_align: next_st.align = wr_data_eff;
          sel_irq_en: next_st.irq_en = wr_data_eff;
          sel_irq_stat: next_st.irq_stat = (st.irq_stat & ~wr_data_eff) | sync_events;
          default: begin
          end
        endcase
      end
    end
    if (bvalid && bready) begin
      next_st.wr_state = wr_collect;
    end
    if (st.r_valid) begin
      if (rready) begin
        next_st.r_valid = 1'b0;
      end
    end else if (arvalid) begin
      next_st.r_valid = 1'b1;
      next_st.r_resp = QPCS_RESP_OKAY;
      case (qpcs_decode(araddr))
        sel_skip_up: next_st.r_data = st.skip_up;
        sel_mask_lo: next_st.r_data = st.mask_lo;
        sel_cha_lo: next_st.r_data = st.cha_lo;
        sel_chb_lo: next_st.r_data = st.chb_lo;
        sel_comma_up: next_st.r_data = st.comma_up;
        sel_mode: next_st.r_data = st.mode;
        sel_align: next_st.r_data = st.align;
        sel_irq_en: next_st.r_data = st.irq_en;
        sel_irq_stat: next_st.r_data = st.irq_stat;
        sel_rsvd: next_st.r_data = QPCS_RST_ZERO;
        default: begin
          next_st.r_data = QPCS_RST_ZERO;
          next_st.r_resp = QPCS_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.wr_state <= wr_collect;
      st.skip_up <= QPCS_RST_SKIP_UP;
      st.mask_lo <= QPCS_RST_MASK_LO;
      st.cha_lo <= QPCS_RST_CHA_LO;
      st.chb_lo <= QPCS_RST_CHB_LO;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration outputs from register bits; mode flags decoded, polynomial taps picked from constants
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cfg.skip_disp_err[i] = st.skip_up[2*i];
      cfg.skip_k_ctrl[i] = st.skip_up[2*i+1];
    end
    cfg.comma_mask = {st.comma_up[QPCS_F_MASK_UP +: 2], st.mask_lo};
    cfg.comma_a = {st.comma_up[QPCS_F_CHA_UP +: 2], st.cha_lo};
    cfg.comma_b = {st.comma_up[QPCS_F_CHB_UP +: 2], st.chb_lo};
    cfg.quad_mode = st.mode[QPCS_F_QMODE +: 2];
    cfg.sonet_mode = (cfg.quad_mode == QPCS_QM_SONET);
    cfg.serdes8_mode = (cfg.quad_mode == QPCS_QM_SER8);
    cfg.generic_8b10b = st.mode[QPCS_F_G8B10B];
    cfg.fibre_channel = st.mode[QPCS_F_FC];
    cfg.pci_express = st.mode[QPCS_F_PCIE];
    cfg.rapidio = st.mode[QPCS_F_RIO];
    cfg.xaui = st.mode[QPCS_F_XAUI];
    cfg.aligner_lock_block = st.align[QPCS_F_NOLOCK];
    cfg.quad_align = st.align[QPCS_F_QUAD_AL];
    cfg.align_ch23 = st.align[QPCS_F_AL23];
    cfg.align_ch01 = st.align[QPCS_F_AL01];
    cfg.tx_gear_2to1 = st.align[QPCS_F_TXGEAR];
    cfg.rx_gear_2to1 = st.align[QPCS_F_RXGEAR];
    cfg.test_poly_long = st.align[QPCS_F_TPOLY];
    cfg.test_poly_taps = cfg.test_poly_long ? QPCS_TPOLY_LONG : QPCS_TPOLY_SHORT;
    cfg.pcie_poly_d10 = st.align[QPCS_F_PPOLY];
    cfg.pcie_poly_taps = cfg.pcie_poly_d10 ? QPCS_PPOLY_D10 : QPCS_PPOLY_D10A;
  end

  // Disabled events stay visible in status but never reach the pin
  assign irq = |(st.irq_stat & st.irq_en);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  skip_bits_a: assert property (wr_fire && wstrb[0] && wvalid && wready
      && wr_sel == sel_skip_up |=> cfg.skip_k_ctrl[3] == $past(wdata[7])
      && cfg.skip_disp_err[0] == $past(wdata[0]))
    else $error("skip pattern bits not updated");
  comma_mask_a: assert property (wr_fire && wr_sel == sel_comma_up
      && (st.w_got ? st.w_lane : wstrb[0])
      |=> cfg.comma_mask[9:8] == $past(wr_data_eff[3:2]))
    else $error("comma mask upper bits wrong");
  comma_char_a: assert property (wr_fire && wr_sel == sel_chb_lo
      && (st.w_got ? st.w_lane : wstrb[0])
      |=> cfg.comma_b[7:0] == $past(wr_data_eff) && $stable(cfg.comma_a))
    else $error("comma character b low bits wrong");
  quad_mode_a: assert property (cfg.serdes8_mode
      |-> st.mode[2:1] == 2'h3 && !cfg.sonet_mode)
    else $error("quad mode decode wrong");
  proto_sel_a: assert property (wr_fire && wr_sel == sel_mode
      && (st.w_got ? st.w_lane : wstrb[0])
      |=> cfg.xaui == $past(wr_data_eff[7]) && cfg.generic_8b10b == $past(wr_data_eff[3]))
    else $error("protocol select not taken");
  align_ctl_a: assert property (wr_fire && wr_sel == sel_align
      && (st.w_got ? st.w_lane : wstrb[0])
      |=> {cfg.rx_gear_2to1, cfg.tx_gear_2to1, cfg.align_ch01, cfg.align_ch23,
           cfg.quad_align, cfg.aligner_lock_block} == $past(wr_data_eff[5:0]))
    else $error("alignment or gearing control wrong");
  poly_sel_a: assert property (!st.align[6] |-> cfg.test_poly_taps == 31'h00000060
      && (st.align[7] || cfg.pcie_poly_taps == 16'h801c))
    else $error("polynomial select wrong");
  sync_loss_a: assert property (st.sync_d[2] && !st.sync_s[2] |=> st.irq_stat[2])
    else $error("sync loss not recorded");
  sync_gain_a: assert property ($rose(st.sync_s[1]) |=> st.irq_stat[5])
    else $error("sync gain not recorded");
  irq_gate_a: assert property (st.irq_en == 8'h00 |-> !irq)
    else $error("request raised while all events disabled");
  wr_resp_a: assert property (wr_fire |=> bvalid)
    else $error("write response missing");

  // Answers stand until taken; one write in flight keeps the bank simple
  wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");
  wr_release_a: assert property (bvalid && bready |=> !bvalid)
    else $error("write response held after bready");
  wr_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  wr_code_a: assert property (wr_fire
      |=> bresp == ($past(wr_sel == sel_none) ? QPCS_RESP_SLVERR : QPCS_RESP_OKAY))
    else $error("write response code wrong");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data missing");
  rd_hold_a: assert property (rvalid && !rready
      |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data changed before rready");
  rd_release_a: assert property (rvalid && rready |=> !rvalid)
    else $error("read data held after rready");
  rd_unmapped_a: assert property (arvalid && arready && qpcs_decode(araddr) == sel_none
      |=> rresp == QPCS_RESP_SLVERR && rdata == 32'h00000000)
    else $error("unmapped read not refused");
  rd_status_a: assert property (arvalid && arready
      && qpcs_decode(araddr) == sel_irq_stat |=> rdata[7:0] == $past(st.irq_stat))
    else $error("status read wrong");

  // Stores land in their own field only
  skip_mid_a: assert property (wr_fire && wr_sel == sel_skip_up
      && (st.w_got ? st.w_lane : wstrb[0])
      |=> cfg.skip_k_ctrl[1] == $past(wr_data_eff[3]) && cfg.skip_disp_err[2] == $past(wr_data_eff[4]))
    else $error("middle skip pattern bits wrong");
  mask_low_a: assert property (wr_fire && wr_sel == sel_mask_lo
      && (st.w_got ? st.w_lane : wstrb[0])
      |=> cfg.comma_mask[7:0] == $past(wr_data_eff))
    else $error("comma mask low bits wrong");
  char_low_a: assert property (wr_fire && wr_sel == sel_cha_lo
      && (st.w_got ? st.w_lane : wstrb[0])
      |=> cfg.comma_a[7:0] == $past(wr_data_eff) && $stable(cfg.comma_b))
    else $error("comma character a low bits wrong");
  comma_up_a: assert property (wr_fire && wr_sel == sel_comma_up
      && (st.w_got ? st.w_lane : wstrb[0])
      |=> cfg.comma_a[9:8] == $past(wr_data_eff[5:4])
      && cfg.comma_b[9:8] == $past(wr_data_eff[7:6]))
    else $error("comma character upper bits wrong");
  proto_mid_a: assert property (wr_fire && wr_sel == sel_mode
      && (st.w_got ? st.w_lane : wstrb[0])
      |=> {cfg.rapidio, cfg.pci_express, cfg.fibre_channel} == $past(wr_data_eff[6:4]))
    else $error("protocol select bits wrong");
  lane_off_a: assert property (wr_fire && !(st.w_got ? st.w_lane : wstrb[0])
      |=> $stable(cfg))
    else $error("write with lane off changed config");
  // Reserved bits are masked on store, so a one here means the mask leaked
  rsvd_bits_a: assert property ((st.mode & ~QPCS_WMASK_MODE) == QPCS_RST_ZERO
      && (st.comma_up & ~QPCS_WMASK_COMMA_UP) == QPCS_RST_ZERO)
    else $error("reserved bit set");
  sonet_code_a: assert property (cfg.quad_mode == QPCS_QM_SONET
      |-> cfg.sonet_mode && !cfg.serdes8_mode)
    else $error("SONET mode decode wrong");
  mode_other_a: assert property (cfg.quad_mode != QPCS_QM_SONET
      && cfg.quad_mode != QPCS_QM_SER8 |-> !cfg.sonet_mode && !cfg.serdes8_mode)
    else $error("other or reserved mode decoded as a mode");
  poly_long_a: assert property (st.align[6] && st.align[7]
      |-> cfg.test_poly_taps == 31'h48000000 && cfg.pcie_poly_taps == 16'hd008)
    else $error("long polynomial select wrong");
  // Reset needs the disable lifted, so it names its own clause
  reset_val_a: assert property (disable iff (1'b0) !aresetn
      |=> st.skip_up == QPCS_RST_SKIP_UP && cfg.comma_mask == {2'h0, QPCS_RST_MASK_LO}
      && cfg.comma_a == {2'h0, QPCS_RST_CHA_LO} && cfg.comma_b == {2'h0, QPCS_RST_CHB_LO}
      && !irq && !bvalid && !rvalid)
    else $error("reset values wrong");

  // Status: events set, write-one clears, set wins over a clear
  sync_quiet_a: assert property (st.sync_s == st.sync_d
      |-> sync_events == QPCS_RST_ZERO)
    else $error("event without a link change");
  loss_all_a: assert property ((st.sync_d & ~st.sync_s) != '0
      |=> (st.irq_stat[3:0] & $past(st.sync_d & ~st.sync_s))
      == $past(st.sync_d & ~st.sync_s))
    else $error("sync loss missing from status");
  gain_all_a: assert property ((st.sync_s & ~st.sync_d) != '0
      |=> (st.irq_stat[7:4] & $past(st.sync_s & ~st.sync_d))
      == $past(st.sync_s & ~st.sync_d))
    else $error("sync gain missing from status");
  stat_sticky_a: assert property (!(wr_fire && wr_sel == sel_irq_stat)
      |=> (st.irq_stat & $past(st.irq_stat)) == $past(st.irq_stat))
    else $error("status bit lost without a clear");
  stat_clear_a: assert property (wr_fire && wr_sel == sel_irq_stat
      && (st.w_got ? st.w_lane : wstrb[0])
      |=> st.irq_stat == ($past(st.irq_stat & ~wr_data_eff) | $past(sync_events)))
    else $error("status clear wrong");
  // A request needs a recorded event or a fresh enable behind it
  irq_cause_a: assert property ($rose(irq)
      |-> $past(sync_events != QPCS_RST_ZERO) || $past(wr_fire && wr_sel == sel_irq_en))
    else $error("request raised without a cause");
  irq_on_a: assert property ((st.irq_stat & st.irq_en) != QPCS_RST_ZERO |-> irq)
    else $error("enabled event without request");

  wr_done_c: cover property (wr_fire ##1 bvalid && bready);
  rd_done_c: cover property (rvalid && rready);
  irq_up_c: cover property ($rose(irq));
  set_clear_c: cover property (wr_fire && wr_sel == sel_irq_stat && |sync_events);
  lane_off_c: cover property (wr_fire && !(st.w_got ? st.w_lane : wstrb[0]));
endmodule

// ===== test/qpcs_config_regs_bench.sv
// Self-checking bench for the quad config bank over AXI4-Lite
module qpcs_config_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import qpcs_pkg::*;
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end

  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [QPCS_AW-1:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata, r;
  logic [3:0] wstrb, link_sync;
  logic [1:0] bresp, rresp;
  logic [9:0] idx;
  qpcs_cfg_type cfg;
  int failures, compares, seed;
  // Bench copy of the bank, index 0 is register 0x13
  logic [7:0] mreg [0:9];
  logic [7:0] mstat;

  qpcs_config_regs qpcs_config_regs_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .link_sync(link_sync), .cfg(cfg),
    .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic mapped(input logic [9:0] i);
    return (i >= 10'h013 && i <= 10'h01c) || i == 10'h085;
  endfunction

  function automatic logic [7:0] mread(input logic [9:0] i);
    if (i == 10'h085) return mstat;
    if (mapped(i)) return mreg[i - 10'h013];
    return 8'h00;
  endfunction

  // Reserved bits and registers keep zero
  function automatic logic [7:0] wmask(input logic [9:0] i);
    case (i)
      10'h017: return 8'hfc;
      10'h018: return 8'hfe;
      10'h01a, 10'h01b: return 8'h00;
      default: return 8'hff;
    endcase
  endfunction

  function automatic qpcs_cfg_type exp_cfg();
    qpcs_cfg_type c;
    logic [7:0] s, u, md, al;
    s = mreg[0];
    u = mreg[4];
    md = mreg[5];
    al = mreg[6];
    c.skip_disp_err = {s[6], s[4], s[2], s[0]};
    c.skip_k_ctrl = {s[7], s[5], s[3], s[1]};
    c.comma_mask = {u[3:2], mreg[1]};
    c.comma_a = {u[5:4], mreg[2]};
    c.comma_b = {u[7:6], mreg[3]};
    c.quad_mode = md[2:1];
    c.sonet_mode = (md[2:1] == 2'h1);
    c.serdes8_mode = (md[2:1] == 2'h3);
    {c.xaui, c.rapidio, c.pci_express, c.fibre_channel, c.generic_8b10b} = md[7:3];
    {c.pcie_poly_d10, c.test_poly_long, c.rx_gear_2to1, c.tx_gear_2to1} = al[7:4];
    {c.align_ch01, c.align_ch23, c.quad_align, c.aligner_lock_block} = al[3:0];
    c.test_poly_taps = al[6] ? 31'h48000000 : 31'h00000060;
    c.pcie_poly_taps = al[7] ? 16'hd008 : 16'h801c;
    return c;
  endfunction

  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Master offers address and data together and keeps bready up until bvalid
  task automatic axw(input logic [9:0] i, input logic [7:0] d, input logic [3:0] st);
    int n;
    logic [31:0] x;
    x = $random(seed);
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    awprot <= x[4:2];
    awvalid <= 1'b1;
    wdata <= {x[31:8], d};
    wstrb <= st;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) begin failures++; stop_test(); end
    bready <= 1'b0;
    `CHK("bresp", mapped(i) ? QPCS_RESP_OKAY : QPCS_RESP_SLVERR, bresp)
    if (st[0] && i == 10'h085) mstat = mstat & ~d;
    else if (st[0] && mapped(i)) mreg[i - 10'h013] = d & wmask(i);
  endtask

  task automatic axr(input logic [9:0] i);
    int n;
    logic [31:0] x;
    x = $random(seed);
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arprot <= x[4:2];
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) begin failures++; stop_test(); end
    rready <= 1'b0;
    `CHK("rdata", {24'h0, mread(i)}, rdata)
    `CHK("rresp", mapped(i) ? QPCS_RESP_OKAY : QPCS_RESP_SLVERR, rresp)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {awaddr, araddr, awprot, arprot, wdata, wstrb, link_sync} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    aresetn = 1'b0;
    seed = 95952;
    failures = 0;
    compares = 0;
    mreg = '{8'h05, 8'h7f, 8'h03, 8'h7c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    mstat = 8'h00;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, reserved places and unmapped words
    `CHK("cfg", exp_cfg(), cfg)
    for (int i = 'h13; i <= 'h1d; i++) axr(10'(i));
    axr(10'h012);
    axr(10'h200);
    // Random stores, some with the byte strobe low, some unmapped
    repeat (40) begin
      r = $random(seed);
      idx = (r[3:0] < 4'ha) ? 10'h013 + 10'(r[3:0]) : 10'h01d;
      axw(idx, r[15:8], {r[19:17], r[16] | r[20]});
      `CHK("cfg", exp_cfg(), cfg)
      axr(idx);
    end
    // Every quad mode code and both polynomial selects
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      axw(10'h018, (r[7:0] & 8'hf9) | 8'(k << 1), 4'h1);
      axw(10'h019, {2'(k), r[5:0]}, 4'h1);
      `CHK("cfg", exp_cfg(), cfg)
    end
    // Link events: loss enabled first, then gain; disabled ones still recorded
    axw(10'h085, 8'hff, 4'h1);
    for (int e = 0; e < 2; e++) begin
      axw(10'h01c, e ? 8'hf0 : 8'h0f, 4'h1);
      for (int ch = 0; ch < 4; ch++) begin
        @(posedge aclk);
        link_sync[ch] <= 1'b1;
        mstat[4 + ch] = 1'b1;
        repeat (5) @(posedge aclk);
        axr(10'h085);
        `CHK("irq", |(mstat & mreg[9]), irq)
        link_sync[ch] <= 1'b0;
        mstat[ch] = 1'b1;
        repeat (5) @(posedge aclk);
        axr(10'h085);
        `CHK("irq", |(mstat & mreg[9]), irq)
        r = $random(seed);
        axw(10'h085, r[7:0], 4'h1);
        axr(10'h085);
        `CHK("irq", |(mstat & mreg[9]), irq)
      end
    end
    stop_test();
  end
endmodule
